// ---- core/dfc_conv_ctrl.sv ----
// dfc_conv_ctrl: top of the output conversion control, apb slave,
// transfer sequencer, interval timer and trigger pin handling.
// assumes apb master on mclk; trigger pin is asynchronous.
`timescale 1ns/10ps
`default_nettype none
module dfc_conv_ctrl
    import dfc_pkg::*;
#(
    parameter int NCH = 8,
    parameter int DEPTH = 1024
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trigIn,
    output logic trigOut,
    output logic trigOe,
    output logic fifoIrq,
    output logic [NCH*16-1:0] dacCode,
    output logic convStrobe
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_MOVE = 3'b010,
        ST_CONV = 3'b100
    } dfc_state_t;

    dfc_state_t st_q, st_d;
    logic [31:0] ctrl_q, ctrl_d, timer_q, timer_d, thr_q, thr_d;
    logic [31:0] tick_q, tick_d;
    logic trigS1_q, trigS2_q, trigS3_q, swStart_q, swStart_d;
    logic trigOut_q, trigOut_d, pend_q, pend_d, conv_q, conv_d;
    logic [1:0] mode;
    logic extSel, trigEdge, tickHit, startCycle, swRst;
    logic access, wrEn, rdEn, mapped, fifoWr;
    logic [31:0] rdMux;
    logic [PTR_W:0] fifoCount;
    logic rdValid, rdReady, replay;
    logic [ENTRY_W-1:0] rdData;
    logic [NCH-1:0] loadCh;
    logic [NCH*16-1:0] holdFlat;
    logic [31:0] timerLoad;

    dfc_stream_if #(.W(ENTRY_W)) wrStream ();

    assign mode = ctrl_q[CTRL_MODE_LSB +: 2];
    assign extSel = ctrl_q[CTRL_EXTSEL_BIT];
    assign replay = (mode == MODE_RECYCLE);

    // apb: zero wait states except fifo writes stall while full;
    // read data registered in setup so it stands through the access
    assign access = psel && penable;
    assign fifoWr = pwrite && (paddr == OFS_FIFO);
    assign pready = fifoWr ? wrStream.ready : 1'b1;
    assign wrEn = access && pwrite && pready;
    assign rdEn = psel && !penable && !pwrite;
    assign swRst = wrEn && (paddr == OFS_CTRL) && pwdata[CTRL_SWRST_BIT];
    assign wrStream.valid = access && fifoWr;
    assign wrStream.data = pwdata[ENTRY_W-1:0];

    always_comb begin
        rdMux = 32'h0000_0000;
        mapped = 1'b1;
        if (paddr == OFS_CTRL) begin
            rdMux = ctrl_q;
        end else if (paddr == OFS_TIMER) begin
            rdMux = timer_q;
        end else if (paddr == OFS_THRESH) begin
            rdMux = thr_q;
        end else if (paddr == OFS_START) begin
            rdMux = 32'h0000_0000;
        end else if (paddr == OFS_FIFO) begin
            rdMux = 32'h0000_0000;
        end else if (paddr == OFS_STATUS) begin
            rdMux[STAT_EMPTY_BIT] = (fifoCount == '0);
            rdMux[STAT_FULL_BIT] = (fifoCount == (PTR_W+1)'(DEPTH));
            rdMux[STAT_THR_BIT] = fifoIrq;
            rdMux[STAT_BUSY_BIT] = (st_q != ST_IDLE);
            rdMux[STAT_CNT_LSB +: PTR_W+1] = fifoCount;
        end else if (paddr >= OFS_CHAN0 &&
                     paddr < OFS_CHAN0 + 8'(NCH*4) && paddr[1:0] == 2'h0) begin
            rdMux[15:0] = holdFlat[(paddr[4:2])*16 +: 16];
        end else begin
            mapped = 1'b0;
        end
    end
    assign pslverr = access && !mapped;

    // interval timer; floor keeps the interval at or above the minimum, with no cap at the maximum
    assign timerLoad = (timer_q < TIMER_RESET) ? TIMER_RESET : timer_q;
    assign tickHit = (tick_q == 32'h0000_0000);
    assign trigEdge = trigS2_q && !trigS3_q;

    always_comb begin
        ctrl_d = ctrl_q;
        timer_d = timer_q;
        thr_d = thr_q;
        swStart_d = 1'b0;
        if (wrEn && paddr == OFS_CTRL) begin
            ctrl_d = pwdata & 32'h0000_000f;
        end
        if (wrEn && paddr == OFS_TIMER) begin
            timer_d = pwdata;
        end
        if (wrEn && paddr == OFS_THRESH) begin
            thr_d = pwdata;
        end
        if (wrEn && paddr == OFS_START) begin
            swStart_d = 1'b1;
        end
        // a shortened interval reloads at once instead of running long
        tick_d = (tickHit || tick_q >= timerLoad) ? timerLoad - 32'h1 :
            tick_q - 32'h1;
        if (mode == MODE_SINGLE || mode == MODE_EXTSCAN) begin
            tick_d = timerLoad - 32'h1;
        end
        // trigger pin drives a pulse per interval in continuous and recycle modes when set as output
        trigOut_d = !extSel && tickHit &&
            (mode == MODE_CONT || mode == MODE_RECYCLE);
    end

    // pending cycle start; a new request while busy is remembered
    always_comb begin
        startCycle = 1'b0;
        case (mode)
            MODE_SINGLE: startCycle = swStart_q ||
                (extSel && trigEdge);
            MODE_EXTSCAN: startCycle = extSel && trigEdge;
            default: startCycle = tickHit;
        endcase
    end

    // sequencer: drain to end-of-sample, then convert
    assign rdReady = (st_q == ST_MOVE);
    always_comb begin
        st_d = st_q;
        pend_d = pend_q || startCycle;
        conv_d = 1'b0;
        loadCh = '0;
        case (st_q)
            ST_IDLE: begin
                if (pend_q) begin
                    pend_d = startCycle;
                    st_d = ST_MOVE;
                end
            end
            ST_MOVE: begin
                if (rdValid) begin
                    loadCh[rdData[TAG_LSB +: 3]] = 1'b1;
                    if (rdData[EOS_BIT]) begin
                        st_d = ST_CONV;
                    end
                end else begin
                    // empty fifo: convert what is held
                    st_d = ST_CONV;
                end
            end
            ST_CONV: begin
                conv_d = 1'b1;
                st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ST_IDLE;
            ctrl_q <= 32'h0000_0000;
            timer_q <= TIMER_RESET;
            thr_q <= THRESH_RESET;
            tick_q <= TIMER_RESET - 32'h1;
            swStart_q <= 1'b0;
            trigS1_q <= 1'b0;
            trigS2_q <= 1'b0;
            trigS3_q <= 1'b0;
            trigOut_q <= 1'b0;
            pend_q <= 1'b0;
            conv_q <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            st_q <= swRst ? ST_IDLE : st_d;
            ctrl_q <= swRst ? 32'h0000_0000 : ctrl_d;
            timer_q <= timer_d;
            thr_q <= thr_d;
            tick_q <= tick_d;
            swStart_q <= swStart_d;
            trigS1_q <= trigIn;
            trigS2_q <= trigS1_q;
            trigS3_q <= trigS2_q;
            trigOut_q <= trigOut_d;
            pend_q <= swRst ? 1'b0 : pend_d;
            conv_q <= swRst ? 1'b0 : conv_d;
            prdata <= rdEn ? rdMux : prdata;
        end
    end

    assign trigOut = trigOut_q;
    assign trigOe = !extSel;
    assign convStrobe = conv_q;
    // threshold level, not sticky
    assign fifoIrq = ({{(31-PTR_W){1'b0}}, fifoCount} <= thr_q);

    dfc_sample_fifo #(.WIDTH(ENTRY_W), .DEPTH(DEPTH), .AW(PTR_W)) uFifo (
        .mclk(mclk),
        .rst_b(rst_b),
        .flush(swRst),
        .wr(wrStream.snk),
        .rdValid(rdValid),
        .rdReady(rdReady),
        .replay(replay),
        .rdData(rdData),
        .count(fifoCount)
    );

    dfc_channel_bank #(.NCH(NCH), .W(16)) uBank (
        .mclk(mclk),
        .rst_b(rst_b),
        .clearAll(swRst),
        .loadCh(loadCh),
        .loadVal(rdData[15:0]),
        .convert(st_q == ST_CONV),
        .holdFlat(holdFlat),
        .dacFlat(dacCode)
    );

    sequence s_moveDone;
        st_q == ST_MOVE ##1 st_q == ST_CONV;
    endsequence
    chk_conv_after_move: assert property (@(posedge mclk) disable iff (!rst_b)
        s_moveDone |=> convStrobe) else $error("no convert after move");
    chk_eos_ends_move: assert property (@(posedge mclk) disable iff (!rst_b)
        (st_q == ST_MOVE && rdValid && rdData[EOS_BIT] && !swRst)
        |=> st_q == ST_CONV) else $error("eos did not end move");
    chk_conv_single: assert property (@(posedge mclk) disable iff (!rst_b)
        convStrobe |=> !convStrobe) else $error("convert not one pulse");
    chk_trig_dir: assert property (@(posedge mclk) disable iff (!rst_b)
        extSel |-> !trigOe) else $error("trigger driven as input");
    chk_pin_single: assert property (@(posedge mclk) disable iff (!rst_b)
        (mode == MODE_EXTSCAN && st_q == ST_IDLE && !pend_q && !trigEdge
         && $stable(mode)) |=> st_q == ST_IDLE)
        else $error("scan started without trigger");
    chk_tick_bound: assert property (@(posedge mclk) disable iff (!rst_b)
        tick_q < $past(timerLoad)) else $error("timer out of range");
    chk_irq_level: assert property (@(posedge mclk) disable iff (!rst_b)
        (fifoCount == '0) |-> fifoIrq) else $error("irq low on empty");
    chk_hold_keep: assert property (@(posedge mclk) disable iff (!rst_b)
        (loadCh == '0 && !swRst) |=> $stable(holdFlat))
        else $error("holding changed without load");
    chk_sw_zero: assert property (@(posedge mclk) disable iff (!rst_b)
        swRst |=> holdFlat[15:0] == ZERO_VOLT_CODE)
        else $error("sw reset not zero volts");
endmodule
`default_nettype wire

// ---- core/dfc_pkg.sv ----
// dfc_pkg: constants, register map and mode codes for the output
// conversion control block. no assumptions beyond a SystemVerilog tool.
package dfc_pkg;
    localparam int NUM_CH = 8;
    localparam int SAMPLE_W = 16;
    localparam int FIFO_DEPTH = 1024;
    localparam int PTR_W = 10;
    // fifo entry: [15:0] code, [18:16] channel tag, [19] end of sample
    localparam int ENTRY_W = 20;
    localparam int TAG_LSB = 16;
    localparam int EOS_BIT = 19;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TIMER = 8'h04;
    localparam logic [7:0] OFS_THRESH = 8'h08;
    localparam logic [7:0] OFS_START = 8'h0c;
    localparam logic [7:0] OFS_FIFO = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_CHAN0 = 8'h20;
    // control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_TRIGOUT_BIT = 2;
    localparam int CTRL_EXTSEL_BIT = 3;
    localparam int CTRL_SWRST_BIT = 4;
    // mode codes
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_CONT = 2'h1;
    localparam logic [1:0] MODE_RECYCLE = 2'h2;
    localparam logic [1:0] MODE_EXTSCAN = 2'h3;
    // status fields
    localparam int STAT_EMPTY_BIT = 0;
    localparam int STAT_FULL_BIT = 1;
    localparam int STAT_THR_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;
    localparam int STAT_CNT_LSB = 16;
    // offset binary mid scale gives zero volts on a +/-10 V span
    localparam logic [15:0] ZERO_VOLT_CODE = 16'h8000;
    // timing: rate and interval limits
    localparam real CLK_MHZ = 250.0;
    localparam real MIN_INTERVAL_US = 12.375;
    localparam real MAX_INTERVAL_S = 2.09;
    localparam int MIN_INTERVAL_CYC = $rtoi(MIN_INTERVAL_US * CLK_MHZ
        + 0.999);
    localparam longint MAX_INTERVAL_CYC = longint'(MAX_INTERVAL_S * 1.0e6
        * CLK_MHZ);
    localparam logic [31:0] TIMER_RESET = 32'(MIN_INTERVAL_CYC);
    localparam logic [31:0] THRESH_RESET = 32'h0000_0010;
endpackage

// ---- core/dfc_stream_if.sv ----
// dfc_stream_if: valid/ready stream between the bus slave and the fifo.
// assumes both ends on mclk.
`timescale 1ns/10ps
`default_nettype none
interface dfc_stream_if #(parameter int W = 20);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- core/dfc_sample_fifo.sv ----
// dfc_sample_fifo: sample store with registered read data and a replay
// port that reads without consuming. assumes a single clock.
`timescale 1ns/10ps
`default_nettype none
module dfc_sample_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 1024,
    parameter int AW = 10
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic flush,
    dfc_stream_if.snk wr,
    output logic rdValid,
    input wire logic rdReady,
    input wire logic replay,
    output logic [WIDTH-1:0] rdData,
    output logic [AW:0] count
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d, repPtr_q, repPtr_d;
    logic [AW:0] cnt_q, cnt_d;
    logic [WIDTH-1:0] data_q;
    logic vld_q, vld_d;
    logic push, pop, fetch, adv;
    logic [AW-1:0] src, hp, nxt;

    assign wr.ready = (cnt_q != (AW+1)'(DEPTH)) && !flush;
    assign push = wr.valid && wr.ready;
    // output register shows the head entry; it is popped only when taken,
    // so a switch into replay still starts at the oldest stored entry
    assign adv = vld_q && rdReady;
    assign hp = replay ? repPtr_q : rdPtr_q;
    // replay wraps after the last written entry
    assign nxt = replay ?
        ((repPtr_q + 1'b1 == wrPtr_q) ? rdPtr_q : repPtr_q + 1'b1) :
        rdPtr_q + 1'b1;
    assign fetch = (!vld_q && cnt_q != '0) ||
        (adv && (replay || cnt_q > (AW+1)'(1)));
    assign pop = adv && !replay;
    assign src = vld_q ? nxt : hp;
    assign rdValid = vld_q;
    assign rdData = data_q;
    assign count = cnt_q;

    always_comb begin
        wrPtr_d = wrPtr_q + AW'(push);
        rdPtr_d = rdPtr_q + AW'(pop);
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        vld_d = fetch ? 1'b1 : (adv ? 1'b0 : vld_q);
        repPtr_d = replay ? (adv ? nxt : repPtr_q) : rdPtr_d;
        if (flush) begin
            wrPtr_d = '0;
            rdPtr_d = '0;
            repPtr_d = '0;
            cnt_d = '0;
            vld_d = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            repPtr_q <= '0;
            cnt_q <= '0;
            vld_q <= 1'b0;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            repPtr_q <= repPtr_d;
            cnt_q <= cnt_d;
            vld_q <= vld_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wrPtr_q] <= wr.data;
        end
        if (fetch) begin
            data_q <= mem[src];
        end
    end
endmodule
`default_nettype wire

// ---- core/dfc_channel_bank.sv ----
// dfc_channel_bank: per-channel holding and converter registers.
// assumes load strobes and the convert strobe come from mclk logic.
`timescale 1ns/10ps
`default_nettype none
module dfc_channel_bank
    import dfc_pkg::*;
#(
    parameter int NCH = 8,
    parameter int W = 16
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clearAll,
    input wire logic [NCH-1:0] loadCh,
    input wire logic [W-1:0] loadVal,
    input wire logic convert,
    output logic [NCH*W-1:0] holdFlat,
    output logic [NCH*W-1:0] dacFlat
);
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gCh
            logic [W-1:0] hold_q, hold_d, dac_q, dac_d;
            always_comb begin
                // untouched channels keep their value
                hold_d = loadCh[g] ? loadVal : hold_q;
                dac_d = convert ? hold_q : dac_q;
                if (clearAll) begin
                    hold_d = ZERO_VOLT_CODE;
                    dac_d = ZERO_VOLT_CODE;
                end
            end
            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    hold_q <= ZERO_VOLT_CODE;
                    dac_q <= ZERO_VOLT_CODE;
                end else begin
                    hold_q <= hold_d;
                    dac_q <= dac_d;
                end
            end
            assign holdFlat[g*W +: W] = hold_q;
            assign dacFlat[g*W +: W] = dac_q;
        end
    endgenerate
endmodule
`default_nettype wire

// ---- verif/dfc_host_model.sv ----
// dfc_host_model: apb master standing in for the host that feeds samples.
// assumes a slave on mclk that may stretch the access phase.
`timescale 1ns/10ps
`default_nettype none
module dfc_host_model
    import dfc_pkg::*;
(
    input wire logic mclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic lastErr;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        lastErr = 1'b0;
    end

    // request held until pready seen high; the bench watchdog ends a hang
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        // response and read data taken at the completing edge
        lastErr = pslverr;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so a following call never reassigns in this step
        @(posedge mclk);
    endtask

    // every entry carries its channel tag; eos closes a transfer
    task automatic push(input int ch, input logic [15:0] code,
            input logic eos);
        logic [31:0] q;
        xfer(1'b1, OFS_FIFO, {12'h000, eos, 3'(ch), code}, q);
    endtask
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// tb: register level tests of the output conversion control.
// assumes interval timer floor and apb timing as the designer stated.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import dfc_pkg::*;
    logic mclk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic trigOut, trigOe, fifoIrq, convStrobe, extEn, extDrv;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [127:0] dacCode;
    int miscompares, nChecks, cyc, trigCnt;
    // pin pulled low when nobody drives it
    wire trigPin = trigOe ? trigOut : (extEn ? extDrv : 1'b0);

    dfc_conv_ctrl dut (.mclk(mclk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trigIn(trigPin), .trigOut(trigOut), .trigOe(trigOe),
        .fifoIrq(fifoIrq), .dacCode(dacCode), .convStrobe(convStrobe));
    dfc_host_model host (.mclk(mclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (trigOe === 1'b1 && trigOut === 1'b1) begin
            trigCnt <= trigCnt + 1;
        end
    end

    task automatic endSim();
        if (miscompares == 0 && nChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic waitConv(output int n);
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (convStrobe !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            miscompares++;
        end
    endtask

    function automatic logic [31:0] dac(input int c);
        return {16'h0000, dacCode[16*c +: 16]};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0, q);
    endtask

    initial begin
        #240000;
        miscompares++;
        endSim();
    end

    initial begin
        rst_b = 1'b0;
        extEn = 1'b0;
        extDrv = 1'b0;
        miscompares = 0;
        nChecks = 0;
        trigCnt = 0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        for (int c = 0; c < NUM_CH; c++) begin
            chk(dac(c), {16'h0, ZERO_VOLT_CODE});
            rd(OFS_CHAN0 + 8'(4 * c));
            chk(q, {16'h0, ZERO_VOLT_CODE});
        end
        chk(32'(fifoIrq), 32'h1);
        rd(8'h18);
        chk({q[30:0], host.lastErr}, 32'h1);
        // single mode: only channels 2 and 5 move
        host.push(2, 16'h1234, 1'b0);
        host.push(5, 16'habcd, 1'b1);
        rd(OFS_STATUS);
        chk({21'h0, q[26:16]}, 32'h2);
        wr(OFS_START, 32'h1);
        waitConv(cyc);
        for (int c = 0; c < NUM_CH; c++) begin
            chk(dac(c), c == 2 ? 32'h1234 : c == 5 ? 32'habcd : 32'h8000);
        end
        rd(OFS_CHAN0 + 8'h08);
        chk(q, 32'h1234);
        // continuous: second sample queued before the next tick
        wr(OFS_THRESH, 32'h1);
        wr(OFS_TIMER, 32'd3200);
        host.push(1, 16'h0001, 1'b1);
        host.push(1, 16'h0002, 1'b1);
        chk(32'(fifoIrq), 32'h0);
        wr(OFS_CTRL, {30'h0, MODE_CONT});
        waitConv(cyc);
        chk(dac(1), 32'h0001);
        chk(32'(fifoIrq), 32'h1);
        waitConv(cyc);
        chk(dac(1), 32'h0002);
        chk(32'(cyc), 32'd3200);
        chk(dac(2), 32'h1234);
        chk(32'(trigCnt >= 2), 32'h1);
        // soft reset, then recycle with a timer below the floor
        wr(OFS_CTRL, 32'h10);
        chk(dac(5), 32'h8000);
        wr(OFS_TIMER, 32'd100);
        host.push(0, 16'h1111, 1'b1);
        host.push(0, 16'h2222, 1'b1);
        wr(OFS_CTRL, {30'h0, MODE_RECYCLE});
        for (int i = 0; i < 3; i++) begin
            waitConv(cyc);
            chk(dac(0), i == 1 ? 32'h2222 : 32'h1111);
        end
        chk(32'(cyc), 32'(MIN_INTERVAL_CYC));
        rd(OFS_STATUS);
        chk({21'h0, q[26:16]}, 32'h2);
        // external scan: pin turned to input and pulsed
        wr(OFS_CTRL, 32'h10);
        host.push(7, 16'h7777, 1'b1);
        wr(OFS_CTRL, {28'h0, 1'b1, 1'b0, MODE_EXTSCAN});
        chk(32'(trigOe), 32'h0);
        extEn <= 1'b1;
        repeat (2) @(posedge mclk);
        extDrv <= 1'b1;
        repeat (4) @(posedge mclk);
        extDrv <= 1'b0;
        waitConv(cyc);
        chk(dac(7), 32'h7777);
        chk(dac(0), 32'h8000);
        extEn <= 1'b0;
        // fill the store to full, then flush it
        wr(OFS_CTRL, 32'h10);
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            host.push(i % NUM_CH, 16'(i), 1'b1);
        end
        rd(OFS_STATUS);
        chk(q & 32'h07ff_0003, {5'h0, 11'(FIFO_DEPTH), 14'h0, 2'b10});
        wr(OFS_CTRL, 32'h10);
        rd(OFS_STATUS);
        chk(q & 32'h07ff_0003, 32'h0000_0001);
        endSim();
    end
endmodule
`default_nettype wire
